// ==== hdl/cis_pkg.sv ====
// Constants, register map and carrier types of the combined interrupt
// and sync status block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`default_nettype none

package cis_pkg;

  // Register bus widths
  localparam int CIS_ADDR_W = 8;
  localparam int CIS_DATA_W = 32;
  localparam int CIS_REG_W = 16;

  // Register byte addresses, one aligned word each
  localparam logic [7:0] CIS_ADDR_COMBINED = 8'h00;
  localparam logic [7:0] CIS_ADDR_COUNTS = 8'h04;
  localparam logic [7:0] CIS_ADDR_BASE = 8'h08;
  localparam logic [7:0] CIS_ADDR_LOCK = 8'h0C;
  localparam logic [7:0] CIS_ADDR_EV_STATUS = 8'h10;
  localparam logic [7:0] CIS_ADDR_EV_MASK = 8'h14;

  // Combined flag register bit positions
  localparam int CIS_BIT_MODULE = 7;
  localparam int CIS_BIT_PROTO = 6;
  localparam int CIS_BIT_HOST_IF = 5;
  localparam int CIS_BIT_WAKEUP = 4;
  localparam int CIS_BIT_FIFO_B = 3;
  localparam int CIS_BIT_FIFO_A = 2;
  localparam int CIS_BIT_RX_BUF = 1;
  localparam int CIS_BIT_TX_BUF = 0;

  // Lock control register bit positions
  localparam int CIS_BIT_EVEN_TRIG = 15;
  localparam int CIS_BIT_ODD_TRIG = 14;
  localparam int CIS_BIT_EVEN_LOCKED = 7;
  localparam int CIS_BIT_ODD_LOCKED = 6;

  // Table base offset alignment bit, always zero
  localparam int CIS_BIT_BASE_ALIGN = 0;

  // Event status and mask layout
  localparam int CIS_EV_W = 3;
  localparam int CIS_EV_UPDATED = 0;
  localparam int CIS_EV_SKIPPED = 1;
  localparam int CIS_EV_MODULE = 2;

  // Reset values
  localparam logic [15:0] CIS_RST_REG = 16'h0000;
  localparam logic [2:0] CIS_RST_EV = 3'h0;
  localparam logic [7:0] CIS_RST_ADDR = 8'h00;
  localparam logic [7:0] CIS_RST_COMB = 8'h00;
  localparam logic [1:0] CIS_RST_STRB = 2'h0;

  // Bus responses
  localparam logic [1:0] CIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIS_RESP_SLVERR = 2'h2;

  // Sync frame counts, packed in register order (b_even at 15..12)
  typedef struct packed {
    logic [3:0] b_even;
    logic [3:0] a_even;
    logic [3:0] b_odd;
    logic [3:0] a_odd;
  } cis_sync_counts_t;

  // Global flags that are mirrored into the combined register
  typedef struct packed {
    logic wakeup;
    logic fifo_b_ne;
    logic fifo_a_ne;
  } cis_global_flags_t;

  // Whole state of the block
  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    cis_sync_counts_t counts;
    logic [15:0] base;
    logic even_lock;
    logic odd_lock;
    logic even_snap;
    logic odd_snap;
    logic [2:0] ev_status;
    logic [2:0] ev_mask;
    logic mif_prev;
    logic [7:0] comb;
  } cis_state_t;

endpackage : cis_pkg

`default_nettype wire

// ==== hdl/cis_top.sv ====
// Combined interrupt flags, sync frame counts and sync table base offset,
// with an AXI4-Lite register slave and a masked event interrupt.
// Assumes all flag and protocol inputs come from logic on CLK.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cis_top
  import cis_pkg::*;
#(
  parameter int NUM_BUFFERS = 16,
  parameter int PROTO_W = 16,
  parameter int HOST_IF_W = 16,
  parameter int OTHER_W = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [CIS_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [CIS_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [CIS_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [CIS_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Individual flag sources
  input wire logic [PROTO_W-1:0] PROTO_FLAGS_0,
  input wire logic [PROTO_W-1:0] PROTO_FLAGS_1,
  input wire logic [HOST_IF_W-1:0] HOST_IF_ERR_FLAGS,
  input wire cis_global_flags_t GLOBAL_FLAGS,
  input wire logic [NUM_BUFFERS-1:0] BUFFER_IRQ_FLAGS,
  input wire logic [NUM_BUFFERS-1:0] BUFFER_DIRECTION,
  input wire logic [OTHER_W-1:0] OTHER_IRQ_FLAGS,
  // Clock synchronisation engine
  input wire logic CYCLE_ODD,
  input wire logic STATIC_END,
  input wire logic SYNC_UPDATE,
  input wire cis_sync_counts_t SYNC_COUNTS,
  // Status towards the rest of the controller
  output logic [7:0] COMBINED_FLAGS,
  output logic [CIS_REG_W-1:0] TABLE_BASE,
  output logic EVEN_LOCKED,
  output logic ODD_LOCKED,
  output logic IRQ
);

  cis_state_t st_q; // Registered state
  cis_state_t st_d; // Next state

  // Combinational flag terms
  logic proto_any; // Any protocol flag
  logic host_if_any; // Any host interface error flag
  logic rx_any; // Any receive buffer flag
  logic tx_any; // Any transmit buffer flag
  logic module_any; // Any source at all
  logic [7:0] comb_now; // Combined register value this cycle

  // Bus handshake terms
  logic aw_take; // Write address taken this edge
  logic w_take; // Write data taken this edge
  logic ar_take; // Read address taken this edge
  logic wr_fire; // Write performed this edge
  logic [7:0] rd_word; // Aligned read address
  logic [7:0] wr_word; // Aligned write address

  // Protocol event terms
  logic even_upd; // Even fields are written
  logic odd_upd; // Odd fields are written
  logic skipped; // Update held back by a lock

  // Merge a 16-bit write under its two byte lanes
  function automatic logic [15:0] cis_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] strb
  );
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction : cis_merge

  // Flag combination, recomputed from the live inputs every clock
  always_comb begin
    // Enable bits never enter here: pure ORs of flags
    proto_any = (|PROTO_FLAGS_0) | (|PROTO_FLAGS_1);
    host_if_any = |HOST_IF_ERR_FLAGS;
    rx_any = |(BUFFER_IRQ_FLAGS & ~BUFFER_DIRECTION);
    tx_any = |(BUFFER_IRQ_FLAGS & BUFFER_DIRECTION);
    module_any = proto_any | host_if_any | rx_any | tx_any
               | GLOBAL_FLAGS.wakeup | GLOBAL_FLAGS.fifo_b_ne
               | GLOBAL_FLAGS.fifo_a_ne | (|OTHER_IRQ_FLAGS);
    comb_now = CIS_RST_COMB;
    comb_now[CIS_BIT_MODULE] = module_any;
    comb_now[CIS_BIT_PROTO] = proto_any;
    comb_now[CIS_BIT_HOST_IF] = host_if_any;
    comb_now[CIS_BIT_WAKEUP] = GLOBAL_FLAGS.wakeup;
    comb_now[CIS_BIT_FIFO_B] = GLOBAL_FLAGS.fifo_b_ne;
    comb_now[CIS_BIT_FIFO_A] = GLOBAL_FLAGS.fifo_a_ne;
    comb_now[CIS_BIT_RX_BUF] = rx_any;
    comb_now[CIS_BIT_TX_BUF] = tx_any;
  end

  // Handshake terms of the register slave
  always_comb begin
    // Each channel is accepted once, no new one while a response waits
    aw_take = S_AXI_AWVALID && !st_q.aw_have && !st_q.bvalid;
    w_take = S_AXI_WVALID && !st_q.w_have && !st_q.bvalid;
    ar_take = S_AXI_ARVALID && !st_q.rvalid;
    wr_fire = st_q.aw_have && st_q.w_have && !st_q.bvalid;
    // Low address bits are ignored, every register is one word
    rd_word = {S_AXI_ARADDR[7:2], 2'h0};
    wr_word = {st_q.awaddr[7:2], 2'h0};
  end

  // Update gating by the locks caught at the end of the static segment
  always_comb begin
    even_upd = SYNC_UPDATE && !CYCLE_ODD && !st_q.even_snap;
    odd_upd = SYNC_UPDATE && CYCLE_ODD && !st_q.odd_snap;
    // An update that neither parity may take is reported as skipped
    skipped = SYNC_UPDATE && !even_upd && !odd_upd;
  end

  // Next state
  always_comb begin
    st_d = st_q;
    // Combined flags follow the sources every cycle
    st_d.comb = comb_now;
    st_d.mif_prev = module_any;

    // Capture write address and data in either order
    if (aw_take) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = S_AXI_AWADDR;
    end
    if (w_take) begin
      // Upper data half and upper strobes carry nothing here
      st_d.w_have = 1'b1;
      st_d.wdata = S_AXI_WDATA[15:0];
      st_d.wstrb = S_AXI_WSTRB[1:0];
    end

    // Lock snapshot at the end of each static segment
    // A toggle in mid-cycle only counts at the next segment end
    if (STATIC_END) begin
      if (CYCLE_ODD) begin
        st_d.odd_snap = st_q.odd_lock;
      end else begin
        st_d.even_snap = st_q.even_lock;
      end
    end

    // Count update in the idle time, on the edge after the pulse
    // Only the two fields of the running parity move
    if (even_upd) begin
      st_d.counts.b_even = SYNC_COUNTS.b_even;
      st_d.counts.a_even = SYNC_COUNTS.a_even;
    end
    if (odd_upd) begin
      st_d.counts.b_odd = SYNC_COUNTS.b_odd;
      st_d.counts.a_odd = SYNC_COUNTS.a_odd;
    end

    // Register write once both halves are held
    if (wr_fire) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = CIS_RESP_OKAY;
      if (wr_word == CIS_ADDR_BASE) begin
        // Bit 0 is forced low for a 16-bit aligned table
        st_d.base = cis_merge(st_q.base, st_q.wdata, st_q.wstrb);
        st_d.base[CIS_BIT_BASE_ALIGN] = 1'b0;
      end else if (wr_word == CIS_ADDR_LOCK) begin
        // Triggers toggle the lock, a zero does nothing
        if (st_q.wstrb[1] && st_q.wdata[CIS_BIT_EVEN_TRIG]) begin
          st_d.even_lock = !st_q.even_lock;
        end
        if (st_q.wstrb[1] && st_q.wdata[CIS_BIT_ODD_TRIG]) begin
          st_d.odd_lock = !st_q.odd_lock;
        end
      end else if (wr_word == CIS_ADDR_EV_STATUS) begin
        // Write one to clear, a set in this cycle still wins below
        if (st_q.wstrb[0]) begin
          st_d.ev_status = st_q.ev_status & ~st_q.wdata[CIS_EV_W-1:0];
        end
      end else if (wr_word == CIS_ADDR_EV_MASK) begin
        // Enables of the interrupt output, one per event
        if (st_q.wstrb[0]) begin
          st_d.ev_mask = st_q.wdata[CIS_EV_W-1:0];
        end
      end else if (wr_word == CIS_ADDR_COMBINED
                   || wr_word == CIS_ADDR_COUNTS) begin
        // Read-only: copies are never a clearing path
        st_d.bresp = CIS_RESP_OKAY;
      end else begin
        // Unmapped
        st_d.bresp = CIS_RESP_SLVERR;
      end
    end

    // Events win over a clear in the same cycle
    // Counts taken for either parity
    if (even_upd || odd_upd) begin
      st_d.ev_status[CIS_EV_UPDATED] = 1'b1;
    end
    // Update refused by a held lock
    if (skipped) begin
      st_d.ev_status[CIS_EV_SKIPPED] = 1'b1;
    end
    // Rising edge of the module flag only
    if (module_any && !st_q.mif_prev) begin
      st_d.ev_status[CIS_EV_MODULE] = 1'b1;
    end

    // Write response retires on its handshake
    if (st_q.bvalid && S_AXI_BREADY) begin
      st_d.bvalid = 1'b0;
    end

    // Read data retires on its handshake
    if (st_q.rvalid && S_AXI_RREADY) begin
      st_d.rvalid = 1'b0;
    end

    // Read: sample the addressed register at the taking edge
    if (ar_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = CIS_RESP_OKAY;
      st_d.rdata = CIS_RST_REG;
      if (rd_word == CIS_ADDR_COMBINED) begin
        // Live flags, not the lagging port copy
        st_d.rdata[CIS_BIT_MODULE:0] = comb_now;
      end else if (rd_word == CIS_ADDR_COUNTS) begin
        // Four fields in register order
        st_d.rdata = st_q.counts;
      end else if (rd_word == CIS_ADDR_BASE) begin
        // Offset with its alignment bit always low
        st_d.rdata = st_q.base;
      end else if (rd_word == CIS_ADDR_LOCK) begin
        // Triggers read as zero, lock states in the low byte
        st_d.rdata[CIS_BIT_EVEN_LOCKED] = st_q.even_lock;
        st_d.rdata[CIS_BIT_ODD_LOCKED] = st_q.odd_lock;
      end else if (rd_word == CIS_ADDR_EV_STATUS) begin
        // Pending events
        st_d.rdata[CIS_EV_W-1:0] = st_q.ev_status;
      end else if (rd_word == CIS_ADDR_EV_MASK) begin
        // Event enables
        st_d.rdata[CIS_EV_W-1:0] = st_q.ev_mask;
      end else begin
        // Unmapped reads return zero with an error
        st_d.rresp = CIS_RESP_SLVERR;
      end
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      // Idle bus, empty registers, both locks open
      st_q.aw_have <= 1'b0;
      st_q.awaddr <= CIS_RST_ADDR;
      st_q.w_have <= 1'b0;
      st_q.wdata <= CIS_RST_REG;
      st_q.wstrb <= CIS_RST_STRB;
      st_q.bvalid <= 1'b0;
      st_q.bresp <= CIS_RESP_OKAY;
      st_q.rvalid <= 1'b0;
      st_q.rdata <= CIS_RST_REG;
      st_q.rresp <= CIS_RESP_OKAY;
      st_q.counts <= CIS_RST_REG;
      st_q.base <= CIS_RST_REG;
      st_q.even_lock <= 1'b0;
      st_q.odd_lock <= 1'b0;
      st_q.even_snap <= 1'b0;
      st_q.odd_snap <= 1'b0;
      st_q.ev_status <= CIS_RST_EV;
      st_q.ev_mask <= CIS_RST_EV;
      st_q.mif_prev <= 1'b0;
      st_q.comb <= CIS_RST_COMB;
    end else begin
      // Whole state moves on every clock
      st_q <= st_d;
    end
  end

  // Port drive
  always_comb begin
    // Readies drop while a channel is held or an answer waits
    S_AXI_AWREADY = !st_q.aw_have && !st_q.bvalid;
    S_AXI_WREADY = !st_q.w_have && !st_q.bvalid;
    S_AXI_BVALID = st_q.bvalid;
    S_AXI_BRESP = st_q.bresp;
    S_AXI_ARREADY = !st_q.rvalid;
    S_AXI_RVALID = st_q.rvalid;
    // Upper half of the read word is always zero
    S_AXI_RDATA = {16'h0000, st_q.rdata};
    S_AXI_RRESP = st_q.rresp;
    // Status towards the rest of the controller
    COMBINED_FLAGS = st_q.comb;
    TABLE_BASE = st_q.base;
    EVEN_LOCKED = st_q.even_lock;
    ODD_LOCKED = st_q.odd_lock;
    // Level interrupt while any unmasked event is pending
    IRQ = |(st_q.ev_status & st_q.ev_mask);
  end

endmodule : cis_top

`default_nettype wire

// ==== bench/cis_props.sv ====
// Checker for the combined flags and the table base output.
// Assumes it is bound into the top block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cis_props
  import cis_pkg::*;
#(
  parameter int NUM_BUFFERS = 16,
  parameter int PROTO_W = 16,
  parameter int HOST_IF_W = 16,
  parameter int OTHER_W = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [PROTO_W-1:0] PROTO_FLAGS_0,
  input wire logic [PROTO_W-1:0] PROTO_FLAGS_1,
  input wire logic [HOST_IF_W-1:0] HOST_IF_ERR_FLAGS,
  input wire cis_global_flags_t GLOBAL_FLAGS,
  input wire logic [NUM_BUFFERS-1:0] BUFFER_IRQ_FLAGS,
  input wire logic [NUM_BUFFERS-1:0] BUFFER_DIRECTION,
  input wire logic [OTHER_W-1:0] OTHER_IRQ_FLAGS,
  input wire logic [7:0] COMBINED_FLAGS,
  input wire logic [CIS_REG_W-1:0] TABLE_BASE
);
  // Buffer flags split by direction
  wire logic rx = |(BUFFER_IRQ_FLAGS & ~BUFFER_DIRECTION);
  wire logic tx = |(BUFFER_IRQ_FLAGS & BUFFER_DIRECTION);
  // Protocol and host interface ORs
  wire logic pr = |{PROTO_FLAGS_0, PROTO_FLAGS_1};
  wire logic hi = |HOST_IF_ERR_FLAGS;
  // Register value the live sources call for
  wire logic [7:0] want = {pr | hi | (|GLOBAL_FLAGS) | (|BUFFER_IRQ_FLAGS)
    | (|OTHER_IRQ_FLAGS), pr, hi, GLOBAL_FLAGS, rx, tx};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_mif; $past(RSTN) |-> COMBINED_FLAGS[7] == $past(want[7]);
  endproperty
  a_mif: assert property (p_mif) else $error("module flag wrong");
  property p_prf; $past(RSTN) |-> COMBINED_FLAGS[6] == $past(want[6]);
  endproperty
  a_prf: assert property (p_prf) else $error("protocol flag wrong");
  property p_hif; $past(RSTN) |-> COMBINED_FLAGS[5] == $past(want[5]);
  endproperty
  a_hif: assert property (p_hif) else $error("host error flag wrong");
  property p_cpy; $past(RSTN) |-> COMBINED_FLAGS[4:2] == $past(want[4:2]);
  endproperty
  a_cpy: assert property (p_cpy) else $error("copied flags wrong");
  property p_rxb; $past(RSTN) |-> COMBINED_FLAGS[1] == $past(rx);
  endproperty
  a_rxb: assert property (p_rxb) else $error("rx buffer flag wrong");
  property p_txb; $past(RSTN) |-> COMBINED_FLAGS[0] == $past(tx);
  endproperty
  a_txb: assert property (p_txb) else $error("tx buffer flag wrong");
  property p_base; TABLE_BASE[0] == 1'b0;
  endproperty
  a_base: assert property (p_base) else $error("base bit 0 set");
  property p_hold; $past(RSTN) && $stable(want) |=> $stable(COMBINED_FLAGS);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved alone");
  // Main scenarios reached
  c_rx: cover property (COMBINED_FLAGS[1]);
  c_tx: cover property (COMBINED_FLAGS[0]);
  c_base: cover property (TABLE_BASE[15]);
endmodule : cis_props
`default_nettype wire

// ==== bench/cis_host.sv ====
// Host model: a register bus master making one write or read at a time.
// Assumes a slave on CLK with valid and ready handshakes on each channel.
`timescale 1ns/1ps
`default_nettype none
module cis_host
  import cis_pkg::*;
(
  input wire logic CLK,
  output logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  output logic [CIS_ADDR_W-1:0] S_AXI_AWADDR,
  output logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  output logic [CIS_DATA_W-1:0] S_AXI_WDATA,
  input wire logic S_AXI_BVALID,
  output logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  output logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  output logic [CIS_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  output logic S_AXI_RREADY,
  input wire logic [CIS_DATA_W-1:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP
);
  int hangs = 0; // Transfers that never got an answer
  // Bus idle from time zero
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_AWADDR} = '0;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_ARADDR, S_AXI_WDATA} = '0;
  end
  // One transfer, write when w is set; q and r carry the answer
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    int n;
    q = '0;
    r = 2'h3;
    @(posedge CLK);
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY <= !w;
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    for (n = 0; n < 64; n++) begin
      @(posedge CLK);
      // Each channel lets go at its own handshake edge
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (w ? S_AXI_BVALID : S_AXI_RVALID) begin
        q = S_AXI_RDATA;
        r = w ? S_AXI_BRESP : S_AXI_RRESP;
        S_AXI_BREADY <= 1'b0;
        S_AXI_RREADY <= 1'b0;
        break;
      end
    end
    if (n == 64) hangs++;
  endtask : xfer
endmodule : cis_host
`default_nettype wire

// ==== bench/cis_tb_top.sv ====
// Bench top: resets the block, drives flag and sync inputs, checks
// registers through the host model. Assumes the package and design.
`timescale 1ns/1ps
`default_nettype none
module cis_tb_top
  import cis_pkg::*;
;
  logic CLK, RSTN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, S_AXI_RREADY, CYCLE_ODD, STATIC_END, SYNC_UPDATE;
  logic EVEN_LOCKED, ODD_LOCKED, IRQ;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, COMBINED_FLAGS, OTHER_IRQ_FLAGS;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [15:0] PROTO_FLAGS_0, PROTO_FLAGS_1, HOST_IF_ERR_FLAGS, TABLE_BASE;
  logic [15:0] BUFFER_IRQ_FLAGS, BUFFER_DIRECTION;
  cis_global_flags_t GLOBAL_FLAGS;
  cis_sync_counts_t SYNC_COUNTS;
  wire logic [2:0] S_AXI_AWPROT = 3'h0; // Protection ignored
  wire logic [2:0] S_AXI_ARPROT = 3'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF; // Byte lanes, whole word by default
  int mismatches = 0;
  int tests_run = 0;
  // Expected flags for each lone source, last entry none
  logic [7:0] comb_exp [10] = '{8'hC0, 8'hC0, 8'hA0, 8'h84, 8'h88, 8'h90,
    8'h82, 8'h81, 8'h80, 8'h00};
  cis_top cis_top_inst (.*);
  cis_host cis_host_inst (.*);
  // 100 ns clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Response compare; a hung transfer ends the run
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t response %h expected %h", $time, got, exp);
    end
    if (cis_host_inst.hangs != 0) begin
      mismatches++;
      $display("FAIL %0t bus timeout", $time);
      end_of_test();
    end
  endtask : chk_resp
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = CIS_RESP_OKAY);
    logic [31:0] q;
    logic [1:0] r;
    cis_host_inst.xfer(1'b0, a, 32'h0, q, r);
    chk(q, e);
    chk_resp(r, er);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = CIS_RESP_OKAY);
    logic [31:0] q;
    logic [1:0] r;
    cis_host_inst.xfer(1'b1, a, d, q, r);
    chk_resp(r, er);
  endtask : wr
  // One source per select bit; buffer 0 and 2 transmit without flags
  task automatic drive_src(input logic [8:0] s);
    @(posedge CLK);
    PROTO_FLAGS_0 <= {15'h0000, s[0]};
    PROTO_FLAGS_1 <= {s[1], 15'h0000};
    HOST_IF_ERR_FLAGS <= {8'h00, s[2], 7'h00};
    GLOBAL_FLAGS <= s[5:3];
    BUFFER_IRQ_FLAGS <= {12'h000, s[6] | s[7], 3'h0};
    BUFFER_DIRECTION <= {12'h000, s[7], 3'h5};
    OTHER_IRQ_FLAGS <= {7'h00, s[8]};
  endtask : drive_src
  // Static segment end, then the idle time count update
  task automatic sync(input logic odd, input logic [15:0] c);
    @(posedge CLK);
    CYCLE_ODD <= odd;
    STATIC_END <= 1'b1;
    @(posedge CLK);
    STATIC_END <= 1'b0;
    SYNC_UPDATE <= 1'b1;
    SYNC_COUNTS <= c;
    @(posedge CLK);
    SYNC_UPDATE <= 1'b0;
  endtask : sync
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  // Main sequence
  initial begin
    RSTN = 1'b0;
    {CYCLE_ODD, STATIC_END, SYNC_UPDATE, SYNC_COUNTS, OTHER_IRQ_FLAGS} = '0;
    {PROTO_FLAGS_0, PROTO_FLAGS_1, HOST_IF_ERR_FLAGS, GLOBAL_FLAGS} = '0;
    {BUFFER_IRQ_FLAGS, BUFFER_DIRECTION} = '0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    rd(CIS_ADDR_COUNTS, 32'h0);
    rd(CIS_ADDR_BASE, 32'h0);
    rd(8'h40, 32'h0, CIS_RESP_SLVERR);
    wr(8'h40, 32'hFFFF, CIS_RESP_SLVERR);
    done("reset");
    for (int i = 0; i < 10; i++) begin
      drive_src(9'h001 << i);
      rd(CIS_ADDR_COMBINED, {24'h0, comb_exp[i]});
      chk(COMBINED_FLAGS, comb_exp[i]);
    end
    drive_src(9'h020);
    wr(CIS_ADDR_COMBINED, 32'hFF);
    rd(CIS_ADDR_COMBINED, 32'h90);
    wr(CIS_ADDR_BASE, 32'hFFFF);
    rd(CIS_ADDR_BASE, 32'hFFFE);
    chk(TABLE_BASE, 32'hFFFE);
    S_AXI_WSTRB <= 4'h1; // Low byte lane only
    wr(CIS_ADDR_BASE, 32'h1235);
    rd(CIS_ADDR_BASE, 32'hFF34);
    wr(CIS_ADDR_LOCK, 32'hC000);
    chk(EVEN_LOCKED, 32'h0);
    S_AXI_WSTRB <= 4'hF;
    done("flags and base");
    sync(1'b0, 16'hABCD);
    rd(CIS_ADDR_COUNTS, 32'hAB00);
    sync(1'b1, 16'h1234);
    rd(CIS_ADDR_COUNTS, 32'hAB34);
    wr(CIS_ADDR_COUNTS, 32'h0);
    wr(CIS_ADDR_LOCK, 32'hC000);
    wr(CIS_ADDR_LOCK, 32'h0);
    chk(EVEN_LOCKED, 32'h1);
    chk(ODD_LOCKED, 32'h1);
    sync(1'b0, 16'h5678);
    sync(1'b1, 16'h5678);
    rd(CIS_ADDR_COUNTS, 32'hAB34);
    wr(CIS_ADDR_LOCK, 32'h8000);
    rd(CIS_ADDR_LOCK, 32'h40);
    sync(1'b0, 16'h5678);
    sync(1'b1, 16'h9999);
    rd(CIS_ADDR_COUNTS, 32'h5634);
    done("sync counts");
    rd(CIS_ADDR_EV_STATUS, 32'h7);
    chk(IRQ, 32'h0);
    wr(CIS_ADDR_EV_MASK, 32'h1);
    chk(IRQ, 32'h1);
    wr(CIS_ADDR_EV_STATUS, 32'h7);
    chk(IRQ, 32'h0);
    rd(CIS_ADDR_EV_STATUS, 32'h0);
    done("interrupt");
    end_of_test();
  end
endmodule : cis_tb_top
bind cis_top cis_props #(.NUM_BUFFERS(NUM_BUFFERS), .PROTO_W(PROTO_W),
  .HOST_IF_W(HOST_IF_W), .OTHER_W(OTHER_W)) cis_props_inst (.*);
`default_nettype wire
